/* File: hw/pgu_pkg.sv */
// pgu_pkg: register map, reset values, pin layout and bus types of the port unit
// assumes: one 125 MHz clock, 16-bit register port with byte addresses as printed
// Behaviour
// R01 - direction one drives pin with data bit
// R02 - direction zero releases pin as input
// R03 - driven level changes on timer clock rise
// R04 - data write to input pin not driven
// R05 - data read returns present pin level
// R06 - carrier detect at bit 13, read-only data
// R07 - reserved register bits read as zero
// R08 - software writes zero to reserved bits
// R09 - enabled pin meeting trigger sets status bit
// R10 - status bits cleared by writing one
// R11 - triggers: any edge, low or high level
// R12 - eleven pins plus carrier detect interrupt; code lets all twelve pins plus carrier detect interrupt
// R13 - pins 13,10,9 sampled by master clock
// R14 - six 16-bit registers at even addresses; code has seven, the seventh being the mask register
// R15 - trigger type one edge, zero level
// R16 - level select picks low or high level
// R17 - enable one allows, zero blocks interrupt
// R18 - output pins still raise enabled interrupts
// R19 - interrupt request high while status set; code raises it only for status bits whose mask bit is set

package pgu_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [31:0] OFF_DIRECTION = 32'h0B00_0100;
    localparam logic [31:0] OFF_DATA      = 32'h0B00_0102;
    localparam logic [31:0] OFF_STATUS    = 32'h0B00_0104;
    localparam logic [31:0] OFF_ENABLE    = 32'h0B00_0106;
    localparam logic [31:0] OFF_TRIGGER   = 32'h0B00_0108;
    localparam logic [31:0] OFF_LEVEL     = 32'h0B00_010A;
    localparam logic [31:0] OFF_MASK      = 32'h0B00_010C;

    // ************************************************************
    // reset values and implemented bits
    // ************************************************************
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] RST_MASK      = 16'h2FFF;
    localparam logic [15:0] DIR_BITS      = 16'h0FFF;
    localparam logic [15:0] IRQ_BITS      = 16'h2FFF;
    localparam logic [15:0] MCLK_PINS     = 16'h2600;
    localparam int          BATT_BIT      = 9;
    localparam int          SYNC_W        = 15;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pgu_bus_req_s;

    typedef struct packed {
        logic [15:0] enable;
        logic [15:0] edgeSel;
        logic [15:0] highSel;
    } pgu_trig_cfg_s;

    // keeps only the implemented bits of a register value
    function automatic logic [15:0] pgu_keep(input logic [15:0] v, input logic [15:0] m);
        return v & m;
    endfunction : pgu_keep

endpackage : pgu_pkg

/* File: hw/pgu_sync.sv */
// pgu_sync: two-stage synchroniser for a vector of asynchronous levels
// assumes: each bit is an independent level, no word coherence needed
`timescale 1ns/1ps
`default_nettype none

module pgu_sync #(
    parameter int W = 1
) (
    // system
    input  wire logic         clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : pgu_sync

`default_nettype wire

/* File: hw/pgu_detect.sv */
// pgu_detect: per-pin trigger detection on sample strobes
// assumes: levels already synchronised, strobes one cycle long
`timescale 1ns/1ps
`default_nettype none

module pgu_detect (
    // system
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // samples
    input  wire logic [15:0]           level,
    input  wire logic [15:0]           strobe,
    input  wire pgu_pkg::pgu_trig_cfg_s cfg,
    // events
    output var  logic [15:0]           setVec
);
    import pgu_pkg::*;

    logic [15:0] prev_r;
    logic [15:0] hitEdge;
    logic [15:0] hitLevel;

    // level seen at the previous strobe of each pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= RST_ZERO;
        end else begin
            prev_r <= (prev_r & ~strobe) | (level & strobe);
        end
    end

    always_comb begin
        hitEdge  = level ^ prev_r;                                  // [R11]
        hitLevel = ~(level ^ cfg.highSel);                          // [R16]
        setVec   = strobe & cfg.enable &                            // [R17]
                   ((cfg.edgeSel & hitEdge) | (~cfg.edgeSel & hitLevel)); // [R15]
    end

endmodule : pgu_detect

`default_nettype wire

/* File: hw/pgu_port_unit.sv */
// pgu_port_unit: twelve-pin port with carrier detect input and pin interrupts
// assumes: pad resolves gpioOut/gpioOe into the wire seen on gpioIn;
// timer and master output clocks arrive as slow asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module pgu_port_unit (
    // system
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // register port
    input  wire pgu_pkg::pgu_bus_req_s busReq,
    output var  logic [15:0]          rdData,
    // port pins
    input  wire logic [11:0]          gpioIn,
    output var  logic [11:0]          gpioOut,
    output var  logic [11:0]          gpioOe,
    input  wire logic                 carrierDetect,
    // sampling clocks
    input  wire logic                 timerClock,
    input  wire logic                 masterOutputClock,
    // system side
    output var  logic                 batteryCoverLockDetect,
    output var  logic                 irq
);
    import pgu_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] syncIn;
    logic [15:0]       pinLevel;
    logic              tclkPrev_r;
    logic              mclkPrev_r;
    logic              tclkRise;
    logic              mclkRise;
    logic [15:0]       strobe;
    logic [15:0]       dirReg_r;
    logic [15:0]       dataReg_r;
    logic [15:0]       status_r;
    logic [15:0]       status_nxt;
    logic [15:0]       enable_r;
    logic [15:0]       trigger_r;
    logic [15:0]       levelSel_r;
    logic [15:0]       mask_r;
    logic [15:0]       setVec;
    logic [15:0]       clrVec;
    logic [15:0]       rdData_r;
    logic [11:0]       gpioOut_r;
    logic [11:0]       gpioOe_r;
    logic              battery_cover_lock_detect_r;
    logic              irq_r;
    pgu_trig_cfg_s     trigCfg;
    logic              wrDir;
    logic              wrData;
    logic              wrStatus;
    logic              wrEnable;
    logic              wrTrigger;
    logic              wrLevel;
    logic              wrMask;

    // ************************************************************
    // input synchronisers and sampling strobes
    // ************************************************************
    assign rawIn = {masterOutputClock, timerClock, carrierDetect, gpioIn};

    pgu_sync #(.W(SYNC_W)) uSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (rawIn),
        .q     (syncIn)
    );

    // carrier detect sits at bit 13, bit 12 stays zero
    assign pinLevel = {2'b00, syncIn[12], 1'b0, syncIn[11:0]};   // [R06] [R07]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tclkPrev_r <= 1'b0;
            mclkPrev_r <= 1'b0;
        end else begin
            tclkPrev_r <= syncIn[13];
            mclkPrev_r <= syncIn[14];
        end
    end

    assign tclkRise = syncIn[13] & ~tclkPrev_r;
    assign mclkRise = syncIn[14] & ~mclkPrev_r;

    // pins 13, 10 and 9 sample on master clock, the rest on timer clock
    assign strobe = ({16{mclkRise}} & MCLK_PINS) |               // [R13]
                    ({16{tclkRise}} & ~MCLK_PINS & IRQ_BITS);    // [R12]

    // ************************************************************
    // write decode
    // ************************************************************
    assign wrDir     = busReq.wr && (busReq.addr == OFF_DIRECTION);
    assign wrData    = busReq.wr && (busReq.addr == OFF_DATA);
    assign wrStatus  = busReq.wr && (busReq.addr == OFF_STATUS);
    assign wrEnable  = busReq.wr && (busReq.addr == OFF_ENABLE);
    assign wrTrigger = busReq.wr && (busReq.addr == OFF_TRIGGER);
    assign wrLevel   = busReq.wr && (busReq.addr == OFF_LEVEL);
    assign wrMask    = busReq.wr && (busReq.addr == OFF_MASK);

    // ************************************************************
    // direction and output data
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dirReg_r <= RST_ZERO;
        end else if (wrDir) begin
            dirReg_r <= pgu_keep(busReq.wdata, DIR_BITS);         // [R14]
        end
    end

    // the written value is held even for input pins, it shows once enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataReg_r <= RST_ZERO;
        end else if (wrData) begin
            dataReg_r <= pgu_keep(busReq.wdata, DIR_BITS);        // [R06]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpioOut_r <= 12'h000;
        end else if (tclkRise) begin
            gpioOut_r <= dataReg_r[11:0];                          // [R03] [R01]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpioOe_r <= 12'h000;
        end else begin
            gpioOe_r <= dirReg_r[11:0];                            // [R02] [R04]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            battery_cover_lock_detect_r <= 1'b0;
        end else begin
            battery_cover_lock_detect_r <= pinLevel[BATT_BIT];                      // [R12]
        end
    end

    // ************************************************************
    // interrupt configuration
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_r <= RST_ZERO;
        end else if (wrEnable) begin
            enable_r <= pgu_keep(busReq.wdata, IRQ_BITS);         // [R17]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigger_r <= RST_ZERO;
        end else if (wrTrigger) begin
            trigger_r <= pgu_keep(busReq.wdata, IRQ_BITS);        // [R15]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            levelSel_r <= RST_ZERO;
        end else if (wrLevel) begin
            levelSel_r <= pgu_keep(busReq.wdata, IRQ_BITS);       // [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_r <= RST_MASK;
        end else if (wrMask) begin
            mask_r <= pgu_keep(busReq.wdata, IRQ_BITS);
        end
    end

    // one driver for the whole configuration word
    assign trigCfg = '{enable: enable_r, edgeSel: trigger_r, highSel: levelSel_r};

    // output pins are detected from the pad level, so they trigger too
    pgu_detect uDetect (                                           // [R18]
        .clk    (clk),
        .rst_n  (rst_n),
        .level  (pinLevel),
        .strobe (strobe),
        .cfg    (trigCfg),
        .setVec (setVec)
    );

    // ************************************************************
    // sticky status and request
    // ************************************************************
    assign clrVec = wrStatus ? pgu_keep(busReq.wdata, IRQ_BITS) : RST_ZERO; // [R10]

    // a set in the same cycle as a clear wins
    assign status_nxt = pgu_keep((status_r & ~clrVec) | setVec, IRQ_BITS); // [R09]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_r <= RST_ZERO;
        end else begin
            status_r <= status_nxt;                                // [R09] [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);                         // [R19]
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_r <= RST_ZERO;
        end else if (busReq.rd) begin
            case (busReq.addr)
                OFF_DIRECTION: rdData_r <= pgu_keep(dirReg_r, DIR_BITS);   // [R07]
                OFF_DATA:      rdData_r <= pgu_keep(pinLevel, IRQ_BITS);   // [R05]
                OFF_STATUS:    rdData_r <= status_r;
                OFF_ENABLE:    rdData_r <= enable_r;
                OFF_TRIGGER:   rdData_r <= trigger_r;
                OFF_LEVEL:     rdData_r <= levelSel_r;
                OFF_MASK:      rdData_r <= mask_r;
                default:       rdData_r <= RST_ZERO;
            endcase
        end else begin
            rdData_r <= RST_ZERO;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdData                 = rdData_r;
    assign gpioOut                = gpioOut_r;
    assign gpioOe                 = gpioOe_r;
    assign batteryCoverLockDetect = battery_cover_lock_detect_r;
    assign irq                    = irq_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    property p_dir_to_oe;
        wrDir |=> ##1 (gpioOe_r == $past(busReq.wdata[11:0], 2));
    endproperty
    a_dir_to_oe: assert property (p_dir_to_oe) // [R01]
        else $error("output enable does not follow direction write");

    property p_input_released;
        (dirReg_r == RST_ZERO) |=> (gpioOe_r == 12'h000);
    endproperty
    a_input_released: assert property (p_input_released) // [R02]
        else $error("input pin still driven");

    property p_out_on_tclk;
        !tclkRise |=> $stable(gpioOut_r);
    endproperty
    a_out_on_tclk: assert property (p_out_on_tclk) // [R03]
        else $error("driven level changed without timer clock rise");

    property p_data_write_no_drive;
        (wrData && !wrDir && (dirReg_r == RST_ZERO)) |=> ##1 (gpioOe_r == 12'h000);
    endproperty
    a_data_write_no_drive: assert property (p_data_write_no_drive) // [R04]
        else $error("data write drove an input pin");

    property p_read_pins;
        (busReq.rd && busReq.addr == OFF_DATA) |=>
            (rdData_r[11:0] == $past(pinLevel[11:0])) && (rdData_r[13] == $past(syncIn[12]));
    endproperty
    a_read_pins: assert property (p_read_pins) // [R05]
        else $error("data read does not show pin levels");

    property p_cd_readonly;
        wrData |=> (dataReg_r[13] == 1'b0);
    endproperty
    a_cd_readonly: assert property (p_cd_readonly) // [R06]
        else $error("carrier detect data bit became writable");

    property p_reserved_zero;
        busReq.rd |=> (rdData_r[15:14] == 2'b00) && (rdData_r[12] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R07]
        else $error("reserved bit read as one");

    property p_dir_reserved;
        (busReq.rd && busReq.addr == OFF_DIRECTION) |=> (rdData_r[15:12] == 4'h0);
    endproperty
    a_dir_reserved: assert property (p_dir_reserved) // [R07]
        else $error("direction reserved bits read as one");

    property p_set_sticks;
        (setVec != RST_ZERO) |=> ((status_r & $past(setVec)) == $past(setVec));
    endproperty
    a_set_sticks: assert property (p_set_sticks) // [R09]
        else $error("trigger did not set status");

    property p_w1c;
        (wrStatus && setVec == RST_ZERO) |=>
            ((status_r & $past(busReq.wdata)) == RST_ZERO) &&
            (status_r == ($past(status_r) & ~$past(busReq.wdata)));
    endproperty
    a_w1c: assert property (p_w1c) // [R10]
        else $error("status write one to clear misbehaved");

    property p_enable_blocks;
        (setVec & ~enable_r) == RST_ZERO;
    endproperty
    a_enable_blocks: assert property (p_enable_blocks) // [R17]
        else $error("disabled pin raised an event");

    property p_mclk_pins;
        ((setVec & MCLK_PINS) != RST_ZERO) |-> mclkRise;
    endproperty
    a_mclk_pins: assert property (p_mclk_pins) // [R13]
        else $error("master clock pin sampled off its strobe");

    property p_irq_follows;
        ((status_r & mask_r) != RST_ZERO) |=> irq_r ##1 1'b1;
    endproperty
    a_irq_follows: assert property (p_irq_follows) // [R19]
        else $error("request missing while status set");

    property p_irq_drops;
        ((status_r & mask_r) == RST_ZERO) |=> !irq_r;
    endproperty
    a_irq_drops: assert property (p_irq_drops) // [R19]
        else $error("request held with no status set");

    c_edge_irq: cover property ((setVec & trigger_r) != RST_ZERO ##2 irq_r);
    c_level_irq: cover property ((setVec & ~trigger_r) != RST_ZERO ##1 status_r != RST_ZERO);
    c_clear: cover property (wrStatus && status_r != RST_ZERO ##1 status_r == RST_ZERO);
    c_drive: cover property (tclkRise && dirReg_r != RST_ZERO ##1 gpioOe_r != 12'h000);

endmodule : pgu_port_unit

`default_nettype wire

/* File: sim/pgu_board.sv */
// pgu_board: board-side model of the twelve port pins
// assumes: the bench requests per-pin board drive; a device-driven pin wins
`timescale 1ns/1ps
`default_nettype none

module pgu_board (
    // system
    input  wire logic        clk,
    // device pad side
    input  wire logic [11:0] gpioOut,
    input  wire logic [11:0] gpioOe,
    // board drivers
    input  wire logic [11:0] extOe,
    input  wire logic [11:0] extVal,
    // resolved wire
    output var  logic [11:0] gpioIn
);
    logic [11:0] floatPat_r = 12'h000;

    // a pin nobody drives wanders every cycle, so no stale level can be read
    always_ff @(posedge clk) begin
        floatPat_r <= ~floatPat_r;
    end

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (gpioOe[i]) begin
                gpioIn[i] = gpioOut[i];
            end else if (extOe[i]) begin
                gpioIn[i] = extVal[i];
            end else begin
                gpioIn[i] = floatPat_r[i];
            end
        end
    end
endmodule : pgu_board

`default_nettype wire

/* File: sim/tb.sv */
// tb: register-level tests of the port unit with a board model on its pins
// assumes: 125 MHz clk, slow free-running timer and master output clocks
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pgu_pkg::*;

    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    pgu_bus_req_s        busReq = '0;
    logic [15:0]         rdData;
    logic [11:0]         gpioIn;
    logic [11:0]         gpioOut;
    logic [11:0]         gpioOe;
    logic                carrierDetect = 1'b0;
    logic                timerClock = 1'b0;
    logic                masterOutputClock = 1'b0;
    logic                battery_cover_lock_detect;
    logic                irq;
    logic [11:0]         extOe = 12'h000;
    logic [11:0]         extVal = 12'h000;
    int                  errCount = 0;
    int                  totalChecks = 0;
    logic [31:0]         regAddr [5] = '{OFF_DIRECTION, OFF_ENABLE, OFF_TRIGGER, OFF_LEVEL,
                                         OFF_MASK};
    logic [15:0]         regBits [5] = '{DIR_BITS, IRQ_BITS, IRQ_BITS, IRQ_BITS, IRQ_BITS};

    // ************************************************************
    // clocks, design and board
    // ************************************************************
    always #4 clk = ~clk;
    initial begin
        #3;
        forever #80 timerClock = ~timerClock;
    end
    initial begin
        #5;
        forever #56 masterOutputClock = ~masterOutputClock;
    end

    pgu_port_unit u_dut (
        .clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .carrierDetect(carrierDetect), .timerClock(timerClock),
        .masterOutputClock(masterOutputClock), .batteryCoverLockDetect(battery_cover_lock_detect), .irq(irq)
    );

    pgu_board u_board (
        .clk(clk), .gpioOut(gpioOut), .gpioOe(gpioOe), .extOe(extOe), .extVal(extVal),
        .gpioIn(gpioIn)
    );

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic regWr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq.addr  <= a;
        busReq.wdata <= d;
        busReq.wr    <= 1'b1;
        @(posedge clk);
        busReq.wr    <= 1'b0;
    endtask : regWr

    task automatic rdChk(input string what, input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk);
        busReq.addr <= a;
        busReq.rd   <= 1'b1;
        @(posedge clk);
        busReq.rd   <= 1'b0;
        #1;
        chk(what, rdData, exp);
    endtask : rdChk

    // two timer clock rises cover at least one master clock rise as well
    task automatic settle();
        @(posedge timerClock);
        @(posedge timerClock);
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic testDone();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : testDone

    initial begin
        #100000;
        errCount++;
        testDone();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdChk("direction", OFF_DIRECTION, RST_ZERO);
        rdChk("status", OFF_STATUS, RST_ZERO);
        rdChk("enable", OFF_ENABLE, RST_ZERO);
        rdChk("trigger", OFF_TRIGGER, RST_ZERO);
        rdChk("level", OFF_LEVEL, RST_ZERO);
        rdChk("mask", OFF_MASK, RST_MASK);
        rdChk("unmapped", 32'h0B00_0110, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            regWr(regAddr[i], 16'hFFFF);
            rdChk("reserved", regAddr[i], regBits[i]);
        end
        chk("oe all", {4'h0, gpioOe}, 16'h0FFF);
        regWr(OFF_ENABLE, 16'h0000);
        regWr(OFF_DIRECTION, 16'h0000);
        regWr(OFF_TRIGGER, 16'h0000);
        regWr(OFF_LEVEL, 16'h0000);
        regWr(OFF_STATUS, 16'h2FFF);
        chk("oe none", {4'h0, gpioOe}, 16'h0000);
        $display("test reserved done");
        regWr(OFF_DIRECTION, 16'h0FFF);
        @(posedge timerClock);
        repeat (4) @(posedge clk);
        regWr(OFF_DATA, 16'h0A5A);
        repeat (3) @(posedge clk);
        chk("out early", {4'h0, gpioOut}, 16'h0000);
        @(posedge timerClock);
        repeat (5) @(posedge clk);
        chk("out", {4'h0, gpioOut}, 16'h0A5A);
        rdChk("data out", OFF_DATA, 16'h0A5A);
        chk("lock", {15'h0, battery_cover_lock_detect}, 16'h0001);
        $display("test output done");
        regWr(OFF_DIRECTION, 16'h00F0);
        extOe         <= 12'hF0F;
        extVal        <= 12'h30C;
        carrierDetect <= 1'b1;
        regWr(OFF_DATA, 16'h0FFF);
        settle();
        chk("oe mix", {4'h0, gpioOe}, 16'h00F0);
        rdChk("data in", OFF_DATA, 16'h23FC);
        carrierDetect <= 1'b0;
        regWr(OFF_DATA, 16'h2FFF);
        settle();
        rdChk("carrier ro", OFF_DATA, 16'h03FC);
        $display("test input done");
        regWr(OFF_DIRECTION, 16'h0000);
        extOe  <= 12'hFFF;
        extVal <= 12'h000;
        regWr(OFF_TRIGGER, 16'h0018);
        regWr(OFF_ENABLE, 16'h0008);
        settle();
        regWr(OFF_STATUS, 16'h2FFF);
        rdChk("no event", OFF_STATUS, 16'h0000);
        extVal <= 12'h018;
        settle();
        rdChk("rise", OFF_STATUS, 16'h0008);
        chk("irq set", {15'h0, irq}, 16'h0001);
        regWr(OFF_STATUS, 16'h0008);
        rdChk("cleared", OFF_STATUS, 16'h0000);
        extVal <= 12'h000;
        settle();
        rdChk("fall", OFF_STATUS, 16'h0008);
        regWr(OFF_STATUS, 16'h0000);
        rdChk("w0 keeps", OFF_STATUS, 16'h0008);
        regWr(OFF_MASK, 16'h0000);
        repeat (3) @(posedge clk);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        regWr(OFF_MASK, 16'h2FFF);
        repeat (3) @(posedge clk);
        chk("irq unmasked", {15'h0, irq}, 16'h0001);
        regWr(OFF_STATUS, 16'h0008);
        repeat (3) @(posedge clk);
        chk("irq drop", {15'h0, irq}, 16'h0000);
        $display("test edge done");
        regWr(OFF_ENABLE, 16'h0000);
        regWr(OFF_TRIGGER, 16'h0000);
        regWr(OFF_LEVEL, 16'h0400);
        extVal <= 12'h400;
        regWr(OFF_ENABLE, 16'h2400);
        settle();
        rdChk("levels", OFF_STATUS, 16'h2400);
        regWr(OFF_ENABLE, 16'h0000);
        regWr(OFF_STATUS, 16'h2FFF);
        rdChk("level off", OFF_STATUS, 16'h0000);
        $display("test level done");
        regWr(OFF_DATA, 16'h0000);
        regWr(OFF_DIRECTION, 16'h0001);
        regWr(OFF_TRIGGER, 16'h0001);
        regWr(OFF_ENABLE, 16'h0001);
        settle();
        regWr(OFF_STATUS, 16'h2FFF);
        regWr(OFF_DATA, 16'h0001);
        settle();
        rdChk("out pin event", OFF_STATUS, 16'h0001);
        regWr(OFF_ENABLE, 16'h0000);
        $display("test output event done");
        testDone();
    end
endmodule : tb

`default_nettype wire
